// ### hw/sae_defs.svh
//==============================================================
// Overview of operation
// - one external input places the access gating in secure mode.
// - in secure mode arrays are secure; direct and high page registers are not.
// - program reads tag fetched bytes secure or non-secure by memory class.
// - secure data read returns zero for non-secure instruction or debug access.
// - secure data write suppressed for non-secure instruction or debug access.
// - stacking writes during interrupt entry are never blocked.
// - a secure-tagged instruction may access secure and non-secure memory.
// - debug accesses to non-secure memory are always allowed.
// - security input low means every access is allowed.
// - program and vector reads of secure arrays always allowed.
// - decoder knows 254 single-byte and 47 prefixed opcodes, 301 total.
// - any reset abandons the current operation at once.
// - reset ends only when source check is done and pin released.
// - after reset fetch vector high then low from top, fill queue, six cycles.
// - interrupt entry starts only at an instruction boundary.
// - vector is that of highest-priority pending request at entry start.
// - push pc low, pc high, index low, accumulator, condition codes in order.
// - after stacking set mask, fetch vector high, low, one idle cycle.
// - fetch three program bytes at the vector to fill the queue.
// - index high byte is never pushed by entry.
// - software trap runs the same entry and ignores the mask.
// - mask set blocks maskable entry; software may clear it.
`ifndef SAE_DEFS_SVH
`define SAE_DEFS_SVH

//==============================================================
// vectors, sequence lengths and opcode counts
`define SAE_RESET_VEC     16'hFFFE
`define SAE_TRAP_VEC      16'hFFFC
`define SAE_STACK_BYTES   3'h5
`define SAE_FILL_BYTES    3'h3
`define SAE_OP_SINGLE     254
`define SAE_OP_PREFIX     47
`define SAE_OP_TOTAL      301

//==============================================================
// register regions (non-secure)
`define SAE_DP_REG_LO     16'h0000
`define SAE_DP_REG_HI     16'h007F
`define SAE_HP_REG_LO     16'h1800
`define SAE_HP_REG_HI     16'h18FF

`endif

// ### hw/sae_pkg.sv
package sae_pkg;

	typedef enum logic [1:0] {
		ACC_PROG,
		ACC_DATA,
		ACC_VECT,
		ACC_STACK
	} sae_kind_type;

	typedef struct packed {
		logic         valid;
		logic         opfetch;
		sae_kind_type kind;
		logic         debug;
		logic         we;
		logic [15:0]  addr;
		logic [7:0]   wdata;
	} sae_req_type;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} sae_mem_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       tag;
		logic       blocked;
	} sae_rsp_type;

	typedef struct packed {
		logic [15:0] pc;
		logic [7:0]  x;
		logic [7:0]  a;
		logic [7:0]  condition_code_register;
	} sae_regs_type;

	typedef enum logic [2:0] {
		SQ_WAIT_RST,
		SQ_IDLE,
		SQ_STACK,
		SQ_VEC_HI,
		SQ_VEC_LO,
		SQ_FREE,
		SQ_FILL
	} sae_seq_type;

endpackage

// ### hw/sae_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "sae_defs.svh"

module sae_gate
	import sae_pkg::*;
(
	// mode and tag
	input  wire logic        secure_i,
	input  wire logic        cur_tag_i,
	// access under test
	input  wire sae_req_type req_i,
	// verdict
	output logic             is_secure_o,
	output logic             rd_ok_o,
	output logic             wr_ok_o
);

	function automatic logic is_register(input logic [15:0] addr);
		return (addr >= `SAE_DP_REG_LO && addr <= `SAE_DP_REG_HI) ||
		       (addr >= `SAE_HP_REG_LO && addr <= `SAE_HP_REG_HI);
	endfunction

	logic trusted;

	always_comb begin
		is_secure_o = secure_i && !is_register(req_i.addr);
		trusted     = cur_tag_i && !req_i.debug;
		rd_ok_o     = !is_secure_o || req_i.kind == ACC_PROG ||
		              req_i.kind == ACC_VECT || trusted;
		wr_ok_o     = !is_secure_o || req_i.kind == ACC_STACK || trusted;
	end

endmodule
`default_nettype wire

// ### hw/sae_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sae_defs.svh"

module sae_core
	import sae_pkg::*;
#(
	parameter logic [15:0] TRAP_VEC = `SAE_TRAP_VEC
)
(
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// pins from outside the clock domain
	input  wire logic         secure_i,
	input  wire logic         src_check_done_i,
	input  wire logic         reset_pin_n_i,
	// execution core
	input  wire sae_req_type  core_req_i,
	input  wire logic         boundary_i,
	input  wire logic         irq_i,
	input  wire logic [15:0]  irq_vector_i,
	input  wire logic         trap_i,
	input  wire logic         mask_clear_i,
	input  wire sae_regs_type regs_i,
	input  wire logic [15:0]  sp_i,
	output sae_rsp_type       core_rsp_o,
	output logic              busy_o,
	output logic              imask_o,
	output logic              cur_tag_o,
	output logic              seq_done_o,
	output logic [15:0]       new_pc_o,
	// memory side
	output sae_mem_type       mem_req_o,
	input  wire logic [7:0]   mem_rdata_i
);

	//==============================================================
	// elaboration checks
	if (`SAE_OP_SINGLE + `SAE_OP_PREFIX != `SAE_OP_TOTAL) begin : g_opchk
		$error("opcode count mismatch");
	end
	if (TRAP_VEC[0] != 1'b0) begin : g_vecchk
		$error("trap vector must be even");
	end

	//==============================================================
	// state
	typedef struct packed {
		logic [1:0]   sec_sync;
		logic [1:0]   chk_sync;
		logic [1:0]   pin_sync;
		sae_seq_type  st;
		logic [2:0]   cnt;
		logic [15:0]  vec_addr;
		logic [15:0]  vec;
		logic [15:0]  sp;
		sae_regs_type saved;
		logic         imask;
		logic         cur_tag;
		logic         stg_valid;
		logic         stg_deliver;
		logic         stg_opfetch;
		logic         stg_sec;
		logic         stg_rd_ok;
		sae_mem_type  mem;
		sae_rsp_type  rsp;
		logic         busy;
		logic         done;
		logic [15:0]  new_pc;
	} sae_state_type;

	sae_state_type s;
	sae_state_type next_s;
	sae_req_type   sel;
	logic          is_sec;
	logic          rd_ok;
	logic          wr_ok;
	logic          entry;
	logic [7:0]    rdata;

	sae_gate u_gate (
		.secure_i    (s.sec_sync[1]),
		.cur_tag_i   (s.cur_tag),
		.req_i       (sel),
		.is_secure_o (is_sec),
		.rd_ok_o     (rd_ok),
		.wr_ok_o     (wr_ok)
	);

	//==============================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.rsp.valid = 1'b0;
		next_s.sec_sync = {s.sec_sync[0], secure_i};
		next_s.chk_sync = {s.chk_sync[0], src_check_done_i};
		next_s.pin_sync = {s.pin_sync[0], reset_pin_n_i};

		// entry only between instructions; trap ignores the mask
		entry = s.st == SQ_IDLE && boundary_i &&
		        (trap_i || (irq_i && !s.imask));

		// read data of the access issued last cycle; memory answers combinationally
		rdata = s.stg_rd_ok ? mem_rdata_i : 8'h00;

		sel = '0;
		unique case (s.st)
			SQ_WAIT_RST: begin
				// hold until the source check is over and the pin is released
				if (s.chk_sync[1] && s.pin_sync[1]) begin
					next_s.vec_addr = `SAE_RESET_VEC;
					next_s.st = SQ_VEC_HI;
				end
			end
			SQ_IDLE: begin
				if (entry) begin
					next_s.vec_addr = trap_i ? TRAP_VEC : irq_vector_i;
					next_s.saved = regs_i;
					next_s.sp = sp_i;
					next_s.cnt = 3'h0;
					next_s.st = SQ_STACK;
				end else begin
					sel = core_req_i;
				end
			end
			SQ_STACK: begin
				sel.valid = 1'b1;
				sel.kind = ACC_STACK;
				sel.we = 1'b1;
				sel.addr = 16'(s.sp - {13'h0000, s.cnt});
				// index high byte is left to the handler
				unique case (s.cnt)
					3'h0: sel.wdata = s.saved.pc[7:0];
					3'h1: sel.wdata = s.saved.pc[15:8];
					3'h2: sel.wdata = s.saved.x;
					3'h3: sel.wdata = s.saved.a;
					default: sel.wdata = s.saved.condition_code_register;
				endcase
				next_s.cnt = 3'(s.cnt + 3'h1);
				if (s.cnt == `SAE_STACK_BYTES - 3'h1) begin
					next_s.st = SQ_VEC_HI;
				end
			end
			SQ_VEC_HI: begin
				sel.valid = 1'b1;
				sel.kind = ACC_VECT;
				sel.addr = s.vec_addr;
				next_s.st = SQ_VEC_LO;
			end
			SQ_VEC_LO: begin
				sel.valid = 1'b1;
				sel.kind = ACC_VECT;
				sel.addr = 16'(s.vec_addr + 16'h0001);
				next_s.vec[15:8] = rdata;
				next_s.st = SQ_FREE;
			end
			SQ_FREE: begin
				// idle bus cycle, lets the low vector byte settle
				next_s.vec[7:0] = rdata;
				next_s.cnt = 3'h0;
				next_s.st = SQ_FILL;
			end
			SQ_FILL: begin
				sel.valid = 1'b1;
				sel.kind = ACC_PROG;
				sel.opfetch = s.cnt == 3'h0;
				sel.addr = 16'(s.vec + {13'h0000, s.cnt});
				next_s.cnt = 3'(s.cnt + 3'h1);
				if (s.cnt == `SAE_FILL_BYTES - 3'h1) begin
					next_s.st = SQ_IDLE;
					next_s.done = 1'b1;
					next_s.new_pc = 16'(s.vec + 16'h0003);
				end
			end
		endcase

		// mask: set after stacking wins over a software clear
		if (s.st == SQ_STACK && s.cnt == `SAE_STACK_BYTES - 3'h1) begin
			next_s.imask = 1'b1;
		end else if (mask_clear_i) begin
			next_s.imask = 1'b0;
		end

		// gated access to memory; a blocked write never reaches the array
		next_s.mem.valid = sel.valid && (!sel.we || wr_ok);
		next_s.mem.we = sel.we;
		next_s.mem.addr = sel.addr;
		next_s.mem.wdata = sel.wdata;
		next_s.stg_valid = sel.valid && !sel.we;
		next_s.stg_deliver = sel.valid && !sel.we && sel.kind != ACC_VECT;
		next_s.stg_opfetch = sel.valid && sel.opfetch && sel.kind == ACC_PROG;
		next_s.stg_sec = is_sec;
		next_s.stg_rd_ok = rd_ok;

		// answer to the core
		if (s.stg_valid && s.stg_deliver) begin
			next_s.rsp.valid = 1'b1;
			next_s.rsp.data = rdata;
			next_s.rsp.tag = s.stg_sec;
			next_s.rsp.blocked = !s.stg_rd_ok;
		end
		if (s.stg_valid && s.stg_opfetch) begin
			next_s.cur_tag = s.stg_sec;
		end
		if (s.st == SQ_IDLE && !entry && sel.valid && sel.we && !wr_ok) begin
			next_s.rsp.valid = 1'b1;
			next_s.rsp.data = 8'h00;
			next_s.rsp.tag = s.cur_tag;
			next_s.rsp.blocked = 1'b1;
		end

		next_s.busy = next_s.st != SQ_IDLE;
	end

	//==============================================================
	// registers; reset drops any sequence in progress
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.st <= SQ_WAIT_RST;
			s.imask <= 1'b1;
			s.busy <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign core_rsp_o = s.rsp;
	assign busy_o     = s.busy;
	assign imask_o    = s.imask;
	assign cur_tag_o  = s.cur_tag;
	assign seq_done_o = s.done;
	assign new_pc_o   = s.new_pc;
	assign mem_req_o  = s.mem;

	//==============================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	logic [15:0] ent_vec;
	assign ent_vec = trap_i ? TRAP_VEC : irq_vector_i;

	sequence s_vec_tail;
		s.st == SQ_VEC_HI ##1 s.st == SQ_VEC_LO ##1 s.st == SQ_FREE
		##1 s.st == SQ_FILL [*3] ##1 s.st == SQ_IDLE && s.done;
	endsequence

	sequence s_stacking;
		(s.st == SQ_STACK && s.mem.valid == 1'b0) ##1
		(s.mem.valid && s.mem.we) [*5];
	endsequence

	property p_rd_zero;
		s.stg_valid && s.stg_deliver && !s.stg_rd_ok |=>
			s.rsp.valid && s.rsp.data == 8'h00 && s.rsp.blocked;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("blocked read not zero");

	property p_wr_block;
		s.st == SQ_IDLE && !entry && sel.valid && sel.we && !wr_ok |=> !s.mem.valid;
	endproperty
	a_wr_block: assert property (p_wr_block) else $error("blocked write reached memory");

	property p_stack_wr;
		entry |=> s_stacking;
	endproperty
	a_stack_wr: assert property (p_stack_wr) else $error("stacking write missing");

	property p_reset_seq;
		s.st == SQ_WAIT_RST && s.chk_sync[1] && s.pin_sync[1] |=> s_vec_tail;
	endproperty
	a_reset_seq: assert property (p_reset_seq) else $error("reset sequence wrong");

	property p_entry_mask;
		entry |=> s.st == SQ_STACK [*5] ##1 s.st == SQ_VEC_HI && s.imask;
	endproperty
	a_entry_mask: assert property (p_entry_mask) else $error("mask not set after stacking");

	property p_masked;
		s.st == SQ_IDLE && boundary_i && irq_i && !trap_i && s.imask |=> s.st == SQ_IDLE;
	endproperty
	a_masked: assert property (p_masked) else $error("masked request entered");

	property p_tag;
		s.stg_valid && s.stg_opfetch |=> s.cur_tag == $past(s.stg_sec);
	endproperty
	a_tag: assert property (p_tag) else $error("tag not latched");

	property p_open;
		!s.sec_sync[1] && sel.valid && sel.we |=> s.mem.valid && s.mem.we;
	endproperty
	a_open: assert property (p_open) else $error("write blocked while open");

	property p_vec_addr;
		logic [15:0] v;
		(entry, v = ent_vec) |-> ##7 s.mem.valid && s.mem.addr == v;
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("wrong vector fetched");

	sequence s_fill;
		(s.st == SQ_FILL && s.cnt == 3'h0) ##1
		(s.mem.valid && !s.mem.we && s.mem.addr == s.vec) ##1
		(s.mem.valid && !s.mem.we && s.mem.addr == 16'(s.vec + 16'h0001)) ##1
		(s.mem.valid && !s.mem.we && s.mem.addr == 16'(s.vec + 16'h0002));
	endsequence

	property p_fill;
		s.st == SQ_FREE |=> s_fill;
	endproperty
	a_fill: assert property (p_fill) else $error("queue fill wrong");

	sequence s_stack_data;
		s.mem.wdata == s.saved.pc[7:0] ##1 s.mem.wdata == s.saved.pc[15:8]
		##1 s.mem.wdata == s.saved.x ##1 s.mem.wdata == s.saved.a
		##1 s.mem.wdata == s.saved.condition_code_register;
	endsequence

	property p_stack_order;
		s.st == SQ_STACK && s.cnt == 3'h0 |=> s_stack_data;
	endproperty
	a_stack_order: assert property (p_stack_order) else $error("stacking order wrong");

	property p_boundary;
		s.st == SQ_IDLE && !boundary_i |=> s.st == SQ_IDLE;
	endproperty
	a_boundary: assert property (p_boundary) else $error("entry away from a boundary");

	property p_trap;
		s.st == SQ_IDLE && boundary_i && trap_i |=> s.st == SQ_STACK;
	endproperty
	a_trap: assert property (p_trap) else $error("trap did not start entry");

	property p_wait_rst;
		s.st == SQ_WAIT_RST && !(s.chk_sync[1] && s.pin_sync[1]) |=>
			s.st == SQ_WAIT_RST && !s.mem.valid;
	endproperty
	a_wait_rst: assert property (p_wait_rst) else $error("left reset wait early");

	// a staged read that is not delivered is a vector read
	property p_vec_rd;
		s.stg_valid && !s.stg_deliver |-> s.stg_rd_ok;
	endproperty
	a_vec_rd: assert property (p_vec_rd) else $error("vector read blocked");

	property p_open_rd;
		s.stg_valid && !s.stg_sec |-> s.stg_rd_ok;
	endproperty
	a_open_rd: assert property (p_open_rd) else $error("open read blocked");

endmodule
`default_nettype wire

// ### verification/sae_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module sae_mem_model
	import sae_pkg::*;
(
	// clock
	input  wire logic        clk_i,
	// request from the block
	input  wire sae_mem_type mem_req_i,
	output logic [7:0]       rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;

	// unselected cycles show the inverse of the last byte, never a held value
	assign rdata_o = (mem_req_i.valid && !mem_req_i.we) ? mem[mem_req_i.addr] : ~last;

	always @(posedge clk_i) begin
		if (mem_req_i.valid && mem_req_i.we) begin
			mem[mem_req_i.addr] <= mem_req_i.wdata;
		end
		if (mem_req_i.valid && !mem_req_i.we) begin
			last <= rdata_o;
		end
	end
endmodule

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sae_defs.svh"

module tb_top
	import sae_pkg::*;
();
	logic         clk_i, rst_n_i, secure_i, src_check_done_i, reset_pin_n_i;
	logic         boundary_i, irq_i, trap_i, mask_clear_i;
	logic         busy_o, imask_o, cur_tag_o, seq_done_o;
	logic [15:0]  irq_vector_i, sp_i, new_pc_o;
	logic [7:0]   mem_rdata_i;
	sae_req_type  core_req_i;
	sae_regs_type regs_i;
	sae_rsp_type  core_rsp_o;
	sae_mem_type  mem_req_o;
	int           n_mismatch = 0;
	int           comparisons = 0;
	int           cyc = 0;
	logic [40:0]  log_q [$];

	sae_core #(.TRAP_VEC(`SAE_TRAP_VEC)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.secure_i(secure_i), .src_check_done_i(src_check_done_i),
		.reset_pin_n_i(reset_pin_n_i), .core_req_i(core_req_i), .boundary_i(boundary_i),
		.irq_i(irq_i), .irq_vector_i(irq_vector_i), .trap_i(trap_i),
		.mask_clear_i(mask_clear_i), .regs_i(regs_i), .sp_i(sp_i), .core_rsp_o(core_rsp_o),
		.busy_o(busy_o), .imask_o(imask_o), .cur_tag_o(cur_tag_o), .seq_done_o(seq_done_o),
		.new_pc_o(new_pc_o), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i));

	sae_mem_model mem_u (.clk_i(clk_i), .mem_req_i(mem_req_o), .rdata_o(mem_rdata_i));

	//==========================================================
	// clock and bus log
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (mem_req_o.valid === 1'h1) begin
			log_q.push_back({cyc[15:0], mem_req_o.we, mem_req_o.addr,
				mem_req_o.we ? mem_req_o.wdata : 8'h00});
		end
	end

	//==========================================================
	// shared tasks
	task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wrap_up;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// flags are {opfetch, debug, we}
	task automatic acc(input sae_kind_type k, input logic [2:0] f, input logic [15:0] a,
		input logic [7:0] d, output sae_rsp_type r);
		int i;
		@(posedge clk_i);
		core_req_i <= '{1'h1, f[2], k, f[1], f[0], a, d};
		@(posedge clk_i);
		core_req_i.valid <= 1'h0;
		r = '0;
		for (i = 0; i < 3; i++) begin
			#1;
			if (core_rsp_o.valid === 1'h1) r = core_rsp_o;
			if (i < 2) @(posedge clk_i);
		end
	endtask

	// e is {blocked, tag}; ed is read data or memory byte after a write
	task automatic step(input sae_kind_type k, input logic [2:0] f, input logic [15:0] a,
		input logic [7:0] d, input logic [7:0] ed, input logic [1:0] e);
		sae_rsp_type r;
		acc(k, f, a, d, r);
		if (f[0]) begin
			chk("wr_rsp", {e[1], e[1]}, {r.valid, r.blocked});
			chk("mem_after", ed, mem_u.mem[a]);
		end else if (k == ACC_VECT) begin
			// vector reads reach memory but are never answered on the response port
			chk("vec_rsp", 1'h0, r.valid);
		end else begin
			chk("rd_rsp", {1'h1, ed, e[1]}, {r.valid, r.data, r.blocked});
		end
		if (k == ACC_PROG) chk("rsp_tag", e[0], r.tag);
		if (f[2]) chk("cur_tag", e[0], cur_tag_o);
	endtask

	task automatic wait_done;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (seq_done_o !== 1'h1 && n < 40);
		chk("seq_done", 1'h1, seq_done_o);
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	task automatic lchk(input int i, input logic we, input logic [15:0] a,
		input logic [7:0] d, input int off);
		if (i < log_q.size()) begin
			chk("mem_req", {off[15:0], we, a, d},
				{log_q[i][40:25] - log_q[0][40:25], log_q[i][24:0]});
		end else begin
			chk("log_len", i + 1, log_q.size());
		end
	endtask

	//==========================================================
	// scenarios
	task automatic t_reset(input logic hold);
		@(posedge clk_i);
		rst_n_i <= 1'h0;
		src_check_done_i <= !hold;
		repeat (2) @(posedge clk_i);
		#1;
		chk("in_reset", 3'h3, {mem_req_o.valid, busy_o, imask_o});
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'h1;
		log_q.delete();
		if (hold) begin
			repeat (8) @(posedge clk_i);
			#1;
			chk("wait_src", 2'h2, {busy_o, log_q.size() != 0});
			@(posedge clk_i);
			src_check_done_i <= 1'h1;
			reset_pin_n_i <= 1'h0;
			repeat (8) @(posedge clk_i);
			#1;
			chk("wait_pin", 2'h2, {busy_o, log_q.size() != 0});
			@(posedge clk_i);
			reset_pin_n_i <= 1'h1;
		end
		wait_done();
		lchk(0, 1'h0, `SAE_RESET_VEC, 8'h00, 0);
		lchk(1, 1'h0, 16'hFFFF, 8'h00, 1);
		lchk(2, 1'h0, 16'h1234, 8'h00, 3);
		lchk(3, 1'h0, 16'h1235, 8'h00, 4);
		lchk(4, 1'h0, 16'h1236, 8'h00, 5);
		chk("reset_end", {32'h5, 16'h1237}, {log_q.size(), new_pc_o});
	endtask

	task automatic t_access;
		mem_u.mem[16'h2000] = 8'hA5;
		mem_u.mem[16'h0010] = 8'h3C;
		mem_u.mem[16'h1810] = 8'hC3;
		@(posedge clk_i);
		secure_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		step(ACC_PROG, 3'h4, 16'h0010, 8'h00, 8'h3C, 2'h0);
		step(ACC_DATA, 3'h0, 16'h2000, 8'h00, 8'h00, 2'h2);
		step(ACC_DATA, 3'h1, 16'h2000, 8'h11, 8'hA5, 2'h2);
		step(ACC_DATA, 3'h0, 16'h1810, 8'h00, 8'hC3, 2'h0);
		step(ACC_PROG, 3'h0, 16'h2000, 8'h00, 8'hA5, 2'h1);
		chk("tag_held", 1'h0, cur_tag_o);
		step(ACC_VECT, 3'h0, 16'h2000, 8'h00, 8'hA5, 2'h0);
		step(ACC_DATA, 3'h2, 16'h0010, 8'h00, 8'h3C, 2'h0);
		step(ACC_DATA, 3'h3, 16'h0012, 8'h99, 8'h99, 2'h0);
		step(ACC_PROG, 3'h4, 16'h2000, 8'h00, 8'hA5, 2'h1);
		step(ACC_DATA, 3'h1, 16'h2000, 8'h5A, 8'h5A, 2'h0);
		step(ACC_DATA, 3'h0, 16'h2000, 8'h00, 8'h5A, 2'h0);
		step(ACC_DATA, 3'h2, 16'h2000, 8'h00, 8'h00, 2'h2);
		step(ACC_DATA, 3'h3, 16'h2000, 8'h66, 8'h5A, 2'h2);
		@(posedge clk_i);
		secure_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		step(ACC_PROG, 3'h4, 16'h0010, 8'h00, 8'h3C, 2'h0);
		step(ACC_DATA, 3'h2, 16'h2000, 8'h00, 8'h5A, 2'h0);
		step(ACC_DATA, 3'h1, 16'h2000, 8'h77, 8'h77, 2'h0);
	endtask

	// secure mode with a non-secure tag, so stacking into secure memory is exercised
	task automatic t_unmask;
		@(posedge clk_i);
		secure_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		step(ACC_PROG, 3'h4, 16'h0010, 8'h00, 8'h3C, 2'h0);
		@(posedge clk_i);
		mask_clear_i <= 1'h1;
		@(posedge clk_i);
		mask_clear_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		#1;
		chk("mask_clear", 1'h0, imask_o);
	endtask

	task automatic entry(input logic trap, input logic [15:0] vec, input logic [15:0] isr);
		logic [7:0] stk [5] = '{8'h21, 8'h43, 8'h55, 8'h66, 8'h77};
		int i;
		mem_u.mem[vec] = isr[15:8];
		mem_u.mem[vec + 16'h1] = isr[7:0];
		@(posedge clk_i);
		log_q.delete();
		boundary_i <= 1'h1;
		irq_i <= !trap;
		trap_i <= trap;
		irq_vector_i <= vec;
		@(posedge clk_i);
		boundary_i <= 1'h0;
		trap_i <= 1'h0;
		irq_vector_i <= 16'hFFE0;
		wait_done();
		for (i = 0; i < 5; i++) begin
			lchk(i, 1'h1, sp_i - i[15:0], stk[i], i);
			chk("stacked", stk[i], mem_u.mem[sp_i - i[15:0]]);
		end
		lchk(5, 1'h0, vec, 8'h00, 5);
		lchk(6, 1'h0, vec + 16'h1, 8'h00, 6);
		for (i = 7; i < 10; i++) begin
			lchk(i, 1'h0, isr + i[15:0] - 16'h7, 8'h00, i + 1);
		end
		chk("log_len", 10, log_q.size());
		chk("entry_end", {1'h1, isr + 16'h3}, {imask_o, new_pc_o});
	endtask

	task automatic t_masked;
		@(posedge clk_i);
		log_q.delete();
		boundary_i <= 1'h1;
		@(posedge clk_i);
		boundary_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		#1;
		chk("masked", 2'h0, {busy_o, log_q.size() != 0});
	endtask

	// reset lands in the middle of stacking
	task automatic t_midrun;
		@(posedge clk_i);
		boundary_i <= 1'h1;
		trap_i <= 1'h1;
		@(posedge clk_i);
		boundary_i <= 1'h0;
		trap_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		t_reset(1'h0);
	endtask

	//==========================================================
	// main sequence and watchdog
	initial begin
		rst_n_i = 1'h0;
		secure_i = 1'h0;
		src_check_done_i = 1'h0;
		reset_pin_n_i = 1'h1;
		core_req_i = '0;
		boundary_i = 1'h0;
		irq_i = 1'h0;
		trap_i = 1'h0;
		mask_clear_i = 1'h0;
		irq_vector_i = 16'h0000;
		sp_i = 16'h01FF;
		regs_i = '{16'h4321, 8'h55, 8'h66, 8'h77};
		mem_u.mem[16'hFFFE] = 8'h12;
		mem_u.mem[16'hFFFF] = 8'h34;
		t_reset(1'h1);
		t_access();
		t_unmask();
		entry(1'h0, 16'hFFF0, 16'h3000);
		t_masked();
		entry(1'h1, `SAE_TRAP_VEC, 16'h4000);
		t_midrun();
		wrap_up();
	end

	// about 200 cycles expected; a generous margin before calling it a hang
	initial begin
		#200000;
		n_mismatch++;
		wrap_up();
	end
endmodule

`default_nettype wire
